// [hw/tmc_timer0.sv]
// Top of the 8-bit timer/counter: registers, counter, compare and waveforms
// What this block does
// - No clock selected means timer never advances
// - Select 1 ticks on every system clock
// - Prescaled ticks divide by 8, 64, 256, 1024
// - Prescaler free running; first count 1..N
// - Software can reset the prescaler
// - Count pin sampled each clock, then synchronised
// - One tick per edge; 7 rising, 6 falling
// - Pin edge reaches counter in about three clocks
// - External ticks never pass the prescaler
// - Counter and both compare values are 8 bits
// - Shared flag register, each flag individually masked
// - Overflow, compare A, compare B interrupt sources
// - Continuous compare; match sets its flag
// - Compare results drive waveforms on two outputs
// - Bottom signalled when counter becomes 0x00
// - Maximum signalled when counter becomes 0xff
// - Top is 0xff or compare A by mode
// - Stopped timer still readable and writable
// - Processor counter write beats clear and count
//
// Our own choices: the register addresses and the address-and-strobe port.
module tmc_timer0
  import tmc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              external_count_input,
  output logic                   compare_output_a,
  output logic                   compare_output_b,
  output logic                   counter_at_bottom,
  output logic                   counter_at_max,
  output logic                   irq_overflow,
  output logic                   irq_compare_a,
  output logic                   irq_compare_b
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tmc_mode_type       mode;
  logic               out_en_a;
  logic               out_en_b;
  logic [2:0]         clock_select;
  logic [7:0]         counter_value;
  logic [7:0]         compare_value_a;
  logic [7:0]         compare_value_b;
  logic [2:0]         timer_flag_register;
  logic [2:0]         timer_mask_register;
  logic               match_block;
  logic [7:0]         next_counter_value;
  logic [2:0]         next_flags;
  logic               next_wave_a;
  logic               next_wave_b;
  logic [DATA_W-1:0]  next_rdata;

  // ----------------------------------------------------------------
  // Clock source
  // ----------------------------------------------------------------
  tmc_tick_if tick_if ();

  tmc_clock_source u_clock_source (
    .mclk                 (mclk),
    .reset                (reset),
    .external_count_input (external_count_input),
    .tick_if              (tick_if)
  );

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] target);
    return addr == target;
  endfunction

  wire wr_control_a = reg_write && reg_hit(reg_addr, REG_CONTROL_A);
  wire wr_control_b = reg_write && reg_hit(reg_addr, REG_CONTROL_B);
  wire wr_counter   = reg_write && reg_hit(reg_addr, REG_COUNTER);
  wire wr_compare_a = reg_write && reg_hit(reg_addr, REG_COMPARE_A);
  wire wr_compare_b = reg_write && reg_hit(reg_addr, REG_COMPARE_B);
  wire wr_flags     = reg_write && reg_hit(reg_addr, REG_FLAGS);
  wire wr_mask      = reg_write && reg_hit(reg_addr, REG_MASK);

  // Prescaler reset is a strobe only; the bit is never stored
  assign tick_if.clock_select    = clock_select;
  assign tick_if.prescaler_reset = wr_control_b && reg_wdata[CTRL_B_PRE_RST_BIT];

  // ----------------------------------------------------------------
  // Counter sequence
  // ----------------------------------------------------------------
  wire       timer_tick = tick_if.timer_tick;
  wire       top_from_a = (mode == MODE_CTC) || (mode == MODE_FAST_PWM_TOP_A);
  wire [7:0] top_value  = top_from_a ? compare_value_a : COUNT_MAX;
  wire       at_top     = counter_value == top_value;
  wire [7:0] count_step = at_top ? COUNT_BOTTOM : 8'(counter_value + 8'h01);
  wire       pwm_mode   = (mode == MODE_FAST_PWM) || (mode == MODE_FAST_PWM_TOP_A);

  // Processor write wins over any count or clear in the same cycle
  assign next_counter_value = wr_counter ? reg_wdata :
                              timer_tick ? count_step :
                              counter_value;

  // ----------------------------------------------------------------
  // Compare and flag events
  // ----------------------------------------------------------------
  // A counter write masks the match of the following tick, so a compare
  // preset equal to the counter does not fire when the clock starts
  wire match_a        = timer_tick && !match_block && (counter_value == compare_value_a);
  wire match_b        = timer_tick && !match_block && (counter_value == compare_value_b);
  wire overflow_event = timer_tick && (counter_value == COUNT_MAX);
  wire [2:0] flag_set = {match_b, match_a, overflow_event};
  wire [2:0] flag_clr = wr_flags ? reg_wdata[2:0] : RESET_FLAGS;

  // Write one clears; a same-cycle event still sets the flag
  assign next_flags = (timer_flag_register & ~flag_clr) | flag_set;

  // Requests: each flag gated by its own mask bit
  assign irq_overflow  = timer_flag_register[FLAG_OVERFLOW_BIT]  && timer_mask_register[FLAG_OVERFLOW_BIT];
  assign irq_compare_a = timer_flag_register[FLAG_COMPARE_A_BIT] && timer_mask_register[FLAG_COMPARE_A_BIT];
  assign irq_compare_b = timer_flag_register[FLAG_COMPARE_B_BIT] && timer_mask_register[FLAG_COMPARE_B_BIT];

  // ----------------------------------------------------------------
  // Waveform generation
  // ----------------------------------------------------------------
  // Non-PWM modes toggle on match; PWM sets at wrap and clears on match.
  // Disabled channels simply hold their state.
  wire wrap_tick = timer_tick && at_top && !wr_counter;

  assign next_wave_a = !out_en_a ? compare_output_a :
                       pwm_mode  ? (wrap_tick ? 1'b1 : (match_a ? 1'b0 : compare_output_a)) :
                       (match_a ? ~compare_output_a : compare_output_a);
  assign next_wave_b = !out_en_b ? compare_output_b :
                       pwm_mode  ? (wrap_tick ? 1'b1 : (match_b ? 1'b0 : compare_output_b)) :
                       (match_b ? ~compare_output_b : compare_output_b);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = RESET_BYTE;
    if (reg_read) begin
      unique case (reg_addr)
        REG_CONTROL_A: next_rdata = {2'h0, out_en_b, out_en_a, 2'h0, mode};
        REG_CONTROL_B: next_rdata = {5'h00, clock_select};
        REG_COUNTER:   next_rdata = counter_value;
        REG_COMPARE_A: next_rdata = compare_value_a;
        REG_COMPARE_B: next_rdata = compare_value_b;
        REG_FLAGS:     next_rdata = {5'h00, timer_flag_register};
        REG_MASK:      next_rdata = {5'h00, timer_mask_register};
        default:       next_rdata = RESET_BYTE;                      // Unmapped reads zero
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Software-written configuration
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      mode                <= MODE_NORMAL;
      out_en_a            <= 1'b0;
      out_en_b            <= 1'b0;
      clock_select        <= CS_STOP;
      compare_value_a     <= RESET_BYTE;
      compare_value_b     <= RESET_BYTE;
      timer_mask_register <= RESET_FLAGS;
    end else begin
      if (wr_control_a) begin
        mode     <= tmc_mode_type'(reg_wdata[CTRL_A_MODE_LSB +: 2]);
        out_en_a <= reg_wdata[CTRL_A_OUT_A_BIT];
        out_en_b <= reg_wdata[CTRL_A_OUT_B_BIT];
      end
      if (wr_control_b) begin
        clock_select <= reg_wdata[CTRL_B_CS_LSB +: 3];
      end
      if (wr_compare_a) begin
        compare_value_a <= reg_wdata;
      end
      if (wr_compare_b) begin
        compare_value_b <= reg_wdata;
      end
      if (wr_mask) begin
        timer_mask_register <= reg_wdata[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter, flags and match blocking
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      counter_value       <= RESET_BYTE;
      timer_flag_register <= RESET_FLAGS;
      match_block         <= 1'b0;
    end else begin
      counter_value       <= next_counter_value;
      timer_flag_register <= next_flags;
      match_block         <= wr_counter ? 1'b1 : (timer_tick ? 1'b0 : match_block);
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Bottom and max follow the next counter value so they align with it
  always_ff @(posedge mclk) begin
    if (reset) begin
      counter_at_bottom <= 1'b1;
      counter_at_max    <= 1'b0;
      compare_output_a  <= 1'b0;
      compare_output_b  <= 1'b0;
      reg_rdata         <= RESET_BYTE;
    end else begin
      counter_at_bottom <= next_counter_value == COUNT_BOTTOM;
      counter_at_max    <= next_counter_value == COUNT_MAX;
      compare_output_a  <= next_wave_a;
      compare_output_b  <= next_wave_b;
      reg_rdata         <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_stopped_idle;
    clock_select == CS_STOP && !wr_counter;
  endsequence

  sequence s_match_a;
    timer_tick && !match_block && !wr_counter && counter_value == compare_value_a;
  endsequence

  property p_stopped;
    s_stopped_idle |=> counter_value == $past(counter_value);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

  property p_direct;
    (clock_select == CS_DIRECT && !wr_counter && !wr_control_b && !at_top) |=>
      counter_value == 8'($past(counter_value) + 8'h01);
  endproperty
  a_direct: assert property (p_direct) else $error("direct clock did not count");

  property p_write_wins;
    wr_counter |=> counter_value == $past(reg_wdata);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("counter write lost");

  property p_match_flag_a;
    s_match_a |=> timer_flag_register[FLAG_COMPARE_A_BIT];
  endproperty
  a_match_flag_a: assert property (p_match_flag_a) else $error("compare A match did not set flag");

  property p_overflow_flag;
    overflow_event |=> timer_flag_register[FLAG_OVERFLOW_BIT];
  endproperty
  a_overflow_flag: assert property (p_overflow_flag) else $error("overflow did not set flag");

  property p_flag_sticky;
    (timer_flag_register[FLAG_COMPARE_B_BIT] && !(wr_flags && reg_wdata[FLAG_COMPARE_B_BIT])) |=>
      timer_flag_register[FLAG_COMPARE_B_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("compare B flag dropped");

  property p_mask_gate;
    irq_compare_b == (timer_flag_register[FLAG_COMPARE_B_BIT] && timer_mask_register[FLAG_COMPARE_B_BIT]);
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("compare B request not masked");

  property p_bottom;
    counter_at_bottom == (counter_value == COUNT_BOTTOM);
  endproperty
  a_bottom: assert property (p_bottom) else $error("bottom indication wrong");

  property p_max;
    counter_at_max == (counter_value == COUNT_MAX);
  endproperty
  a_max: assert property (p_max) else $error("max indication wrong");

  property p_ctc_top;
    (mode == MODE_CTC && timer_tick && !wr_counter && counter_value == compare_value_a) |=>
      counter_value == COUNT_BOTTOM;
  endproperty
  a_ctc_top: assert property (p_ctc_top) else $error("CTC did not clear at compare A");

  property p_read_counter;
    (reg_read && reg_addr == REG_COUNTER) |=> reg_rdata == $past(counter_value);
  endproperty
  a_read_counter: assert property (p_read_counter) else $error("counter read mismatch");

  // Compare B, match blocking, waveform and masking checks
  sequence s_match_b;
    timer_tick && !match_block && !wr_counter && counter_value == compare_value_b;
  endsequence

  sequence s_write_then_tick;
    wr_counter ##1 (timer_tick && !timer_flag_register[FLAG_COMPARE_A_BIT]);
  endsequence

  property p_match_flag_b;
    s_match_b |=> timer_flag_register[FLAG_COMPARE_B_BIT];
  endproperty
  a_match_flag_b: assert property (p_match_flag_b) else $error("compare B match lost");

  property p_match_blocked;
    s_write_then_tick |=> !timer_flag_register[FLAG_COMPARE_A_BIT];
  endproperty
  a_match_blocked: assert property (p_match_blocked) else $error("match not blocked");

  property p_toggle_a;
    (out_en_a && !pwm_mode && match_a) |=> compare_output_a != $past(compare_output_a);
  endproperty
  a_toggle_a: assert property (p_toggle_a) else $error("output A did not toggle");

  property p_pwm_set_b;
    (out_en_b && pwm_mode && wrap_tick) |=> compare_output_b;
  endproperty
  a_pwm_set_b: assert property (p_pwm_set_b) else $error("output B not set at wrap");

  property p_hold_b;
    !out_en_b |=> $stable(compare_output_b);
  endproperty
  a_hold_b: assert property (p_hold_b) else $error("disabled output B moved");

  property p_mask_ov;
    !timer_mask_register[FLAG_OVERFLOW_BIT] |-> !irq_overflow;
  endproperty
  a_mask_ov: assert property (p_mask_ov) else $error("overflow request not masked");

  property p_flag_clear_a;
    (wr_flags && reg_wdata[FLAG_COMPARE_A_BIT] && !match_a) |=> !timer_flag_register[FLAG_COMPARE_A_BIT];
  endproperty
  a_flag_clear_a: assert property (p_flag_clear_a) else $error("compare A flag not cleared");

endmodule

// [hw/tmc_pkg.sv]
// Constants, field layout and mode types of the timer/counter core
package tmc_pkg;

  // ----------------------------------------------------------------
  // Register port geometry and register offsets
  // ----------------------------------------------------------------
  localparam int          ADDR_W            = 3;
  localparam int          DATA_W            = 8;
  localparam logic [2:0]  REG_CONTROL_A     = 3'h0;
  localparam logic [2:0]  REG_CONTROL_B     = 3'h1;
  localparam logic [2:0]  REG_COUNTER       = 3'h2;
  localparam logic [2:0]  REG_COMPARE_A     = 3'h3;
  localparam logic [2:0]  REG_COMPARE_B     = 3'h4;
  localparam logic [2:0]  REG_FLAGS         = 3'h5;
  localparam logic [2:0]  REG_MASK          = 3'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          CTRL_A_MODE_LSB   = 0;
  localparam int          CTRL_A_OUT_A_BIT  = 4;
  localparam int          CTRL_A_OUT_B_BIT  = 5;
  localparam int          CTRL_B_CS_LSB     = 0;
  localparam int          CTRL_B_PRE_RST_BIT = 7;
  localparam int          FLAG_OVERFLOW_BIT = 0;
  localparam int          FLAG_COMPARE_A_BIT = 1;
  localparam int          FLAG_COMPARE_B_BIT = 2;

  // ----------------------------------------------------------------
  // Clock-select codes, prescaler taps, counter limits, reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  CS_STOP           = 3'h0;
  localparam logic [2:0]  CS_DIRECT         = 3'h1;
  localparam logic [2:0]  CS_DIV8           = 3'h2;
  localparam logic [2:0]  CS_DIV64          = 3'h3;
  localparam logic [2:0]  CS_DIV256         = 3'h4;
  localparam logic [2:0]  CS_DIV1024        = 3'h5;
  localparam logic [2:0]  CS_EXT_FALL       = 3'h6;
  localparam logic [2:0]  CS_EXT_RISE       = 3'h7;
  localparam int          PRESCALE_W        = 10;
  localparam logic [9:0]  TAP_MASK_8        = 10'h007;
  localparam logic [9:0]  TAP_MASK_64       = 10'h03f;
  localparam logic [9:0]  TAP_MASK_256      = 10'h0ff;
  localparam logic [9:0]  TAP_MASK_1024     = 10'h3ff;
  localparam logic [7:0]  COUNT_BOTTOM      = 8'h00;
  localparam logic [7:0]  COUNT_MAX         = 8'hff;
  localparam logic [7:0]  RESET_BYTE        = 8'h00;
  localparam logic [2:0]  RESET_FLAGS       = 3'h0;

  // Counting sequence and waveform style
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_CTC,
    MODE_FAST_PWM,
    MODE_FAST_PWM_TOP_A
  } tmc_mode_type;

endpackage

// [hw/tmc_tick_if.sv]
// Carrier between the clock-source front end and the counter core
interface tmc_tick_if;
  logic [2:0] clock_select;
  logic       prescaler_reset;
  logic       timer_tick;

  modport source (input clock_select, input prescaler_reset, output timer_tick);
  modport sink   (output clock_select, output prescaler_reset, input timer_tick);
endinterface

// [hw/tmc_clock_source.sv]
// Free-running prescaler, count-pin synchroniser and timer tick selection
module tmc_clock_source
  import tmc_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     reset,
  input  wire logic     external_count_input,
  tmc_tick_if.source    tick_if
);

  logic [PRESCALE_W-1:0] prescale;
  logic                  ext_meta;
  logic                  ext_sync;
  logic                  ext_prev;
  logic                  ext_rise;
  logic                  ext_fall;
  logic                  timer_tick;

  // True when every bit under the tap mask is set: one cycle per period
  function automatic logic tap_hit(input logic [PRESCALE_W-1:0] cnt, input logic [PRESCALE_W-1:0] mask);
    return (cnt & mask) == mask;
  endfunction

  // Prescaler runs whatever the clock selection; only system reset or its own reset stops it
  always_ff @(posedge mclk) begin
    if (reset || tick_if.prescaler_reset) begin
      prescale <= '0;
    end else begin
      prescale <= PRESCALE_W'(prescale + 1'b1);
    end
  end

  // Pin sampled once per clock; meta feeds only the second stage
  always_ff @(posedge mclk) begin
    if (reset) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= external_count_input;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // Edge detector: one pulse per edge, never through the prescaler
  assign ext_rise = ext_sync & ~ext_prev;
  assign ext_fall = ~ext_sync & ext_prev;

  // Clock-select mux; code 0 gives no tick at all
  always_comb begin
    unique case (tick_if.clock_select)
      CS_STOP:     timer_tick = 1'b0;
      CS_DIRECT:   timer_tick = 1'b1;
      CS_DIV8:     timer_tick = tap_hit(prescale, TAP_MASK_8);
      CS_DIV64:    timer_tick = tap_hit(prescale, TAP_MASK_64);
      CS_DIV256:   timer_tick = tap_hit(prescale, TAP_MASK_256);
      CS_DIV1024:  timer_tick = tap_hit(prescale, TAP_MASK_1024);
      CS_EXT_FALL: timer_tick = ext_fall;
      CS_EXT_RISE: timer_tick = ext_rise;
    endcase
  end
  assign tick_if.timer_tick = timer_tick;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_prescaler_free;
    !tick_if.prescaler_reset |=> prescale == PRESCALE_W'($past(prescale) + 1'b1);
  endproperty
  a_prescaler_free: assert property (p_prescaler_free) else $error("prescaler did not advance");

  property p_prescaler_reset;
    tick_if.prescaler_reset |=> prescale == '0;
  endproperty
  a_prescaler_reset: assert property (p_prescaler_reset) else $error("prescaler reset ignored");

  property p_div8_spacing;
    (tick_if.clock_select == CS_DIV8 && timer_tick && !tick_if.prescaler_reset) |=>
      (!timer_tick || tick_if.clock_select != CS_DIV8)[*7];
  endproperty
  a_div8_spacing: assert property (p_div8_spacing) else $error("divide-by-8 tick too early");

  property p_ext_tick_edge;
    (tick_if.clock_select == CS_EXT_RISE && timer_tick) |-> ext_sync && !$past(ext_sync);
  endproperty
  a_ext_tick_edge: assert property (p_ext_tick_edge) else $error("rising tick without edge");

endmodule

// [test/tmc_ext_clk_model.sv]
// Behavioural external clock source driving the count pin
module tmc_ext_clk_model (
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic [7:0] pulse_count,
  output logic            pin,
  output logic            done
);
  timeunit 1ns;
  timeprecision 1ns;
  // Two clocks per half period keeps the rate below clk/2.5
  localparam int HALF_CYCLES = 2;
  // ----------------------------------------------------------------
  // Burst generator
  // ----------------------------------------------------------------
  // Pin rests low between bursts so select changes see it stable
  initial begin
    pin  = 1'b0;
    done = 1'b1;
    forever begin
      @(posedge go);
      done = 1'b0;
      repeat (2 * pulse_count) begin
        repeat (HALF_CYCLES) @(posedge mclk);
        #37 pin = ~pin; // Off the clock edge, like a free oscillator
      end
      repeat (4) @(posedge mclk);
      done = 1'b1;
    end
  end
endmodule

// [test/tb_top.sv]
// Self-checking bench for the timer/counter core
module tb_top
  import tmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              mclk, reset, reg_write, reg_read, go, pin, ext_done;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd0, rd1, lfsr;
  logic [7:0]        pulse_count;
  logic              out_a, out_b, at_bottom, at_max, irq_ov, irq_a, irq_b;
  int                mismatches, samples_checked, cycles, model_count;
  int                divs [4] = '{8, 64, 256, 1024};
  // ----------------------------------------------------------------
  // Design, partner and clock
  // ----------------------------------------------------------------
  tmc_timer0 dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .external_count_input(pin),
    .compare_output_a(out_a), .compare_output_b(out_b), .counter_at_bottom(at_bottom),
    .counter_at_max(at_max), .irq_overflow(irq_ov), .irq_compare_a(irq_a), .irq_compare_b(irq_b));
  tmc_ext_clk_model src (.mclk(mclk), .go(go), .pulse_count(pulse_count), .pin(pin), .done(ext_done));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] next_lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      mismatches++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, expected);
    end
  endtask
  task automatic wr(input logic [2:0] addr, input logic [7:0] data);
    @(posedge mclk);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [2:0] addr, output logic [7:0] data);
    @(posedge mclk);
    reg_addr <= addr;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 data = reg_rdata;
  endtask
  task automatic start_burst(input logic [7:0] k);
    @(posedge mclk);
    pulse_count <= k;
    go          <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Hang guard sized well above the longest sequence
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {reset, reg_write, reg_read, go} = 4'h8;
    {reg_addr, reg_wdata, pulse_count} = '0;
    {mismatches, samples_checked, model_count} = '0;
    lfsr = 8'h23;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), rd0);
      check(rd0, 8'h00);
    end
    check({7'h00, at_bottom}, 8'h01);
    // Stopped timer: every byte register holds what software wrote
    for (int a = 2; a < 5; a++) begin
      lfsr = next_lfsr(lfsr);
      wr(3'(a), lfsr);
      rd(3'(a), rd0);
      check(rd0, lfsr);
    end
    wr(REG_COUNTER, 8'hff);
    repeat (20) @(posedge mclk);
    rd(REG_COUNTER, rd0);
    check(rd0, 8'hff);
    check({6'h00, at_max, at_bottom}, 8'h02);
    // Direct clock: one count per clock, write beats the tick
    wr(REG_CONTROL_B, {5'h00, CS_DIRECT});
    rd(REG_COUNTER, rd0);
    repeat (40) @(posedge mclk);
    rd(REG_COUNTER, rd1);
    check(rd1 - rd0, 8'h2a);
    wr(REG_COUNTER, 8'h10);
    rd(REG_COUNTER, rd0);
    check(rd0, 8'h11);
    lfsr = next_lfsr(lfsr);
    wr(REG_COMPARE_A, lfsr);
    wr(REG_COMPARE_B, ~lfsr);
    wr(REG_MASK, 8'h05);
    repeat (300) @(posedge mclk);
    rd(REG_FLAGS, rd0);
    check(rd0, 8'h07);
    check({5'h00, irq_b, irq_a, irq_ov}, 8'h05);
    wr(REG_CONTROL_B, 8'h00);
    wr(REG_FLAGS, 8'h07);
    rd(REG_FLAGS, rd0);
    check(rd0, 8'h00);
    // Prescaler reset then the first /64 count lands after 64 clocks
    wr(REG_COUNTER, 8'h00);
    wr(REG_CONTROL_B, {1'b1, 4'h0, CS_DIV64});
    repeat (30) @(posedge mclk);
    rd(REG_COUNTER, rd0);
    check(rd0, 8'h00);
    repeat (60) @(posedge mclk);
    rd(REG_COUNTER, rd0);
    check(rd0, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(REG_CONTROL_B, 8'(CS_DIV8) + 8'(i));
      rd(REG_COUNTER, rd0);
      repeat (3 * divs[i] - 2) @(posedge mclk);
      rd(REG_COUNTER, rd1);
      check(rd1 - rd0, 8'h03);
    end
    // Compare A as top, output A toggling on each match
    wr(REG_CONTROL_B, 8'h00);
    wr(REG_COUNTER, 8'h00);
    wr(REG_COMPARE_A, 8'h09);
    wr(REG_CONTROL_A, 8'h11);
    wr(REG_CONTROL_B, {5'h00, CS_DIRECT});
    rd(REG_COUNTER, rd0);
    repeat (8) @(posedge mclk);
    rd(REG_COUNTER, rd1);
    check(rd0, 8'h01);
    check(rd1, 8'h01);
    check({7'h00, out_a}, 8'h01);
    repeat (10) @(posedge mclk);
    #1 check({7'h00, out_a}, 8'h00);
    // Fast PWM, top A then top 0xff: output B high for counts 0..4
    wr(REG_COMPARE_B, 8'h04);
    for (int m = 0; m < 2; m++) begin
      wr(REG_CONTROL_A, m == 0 ? 8'h23 : 8'h22);
      repeat (260) @(posedge mclk);
      rd0 = 8'h00;
      repeat (m == 0 ? 10 : 256) begin
        @(posedge mclk);
        #1 rd0 += {7'h00, out_b};
      end
      check(rd0, 8'h05);
    end
    // External pin bursts on both edge kinds, counted by the model
    wr(REG_CONTROL_A, 8'h00);
    wr(REG_CONTROL_B, 8'h00);
    wr(REG_COUNTER, 8'h00);
    for (int e = 0; e < 2; e++) begin
      wr(REG_CONTROL_B, e == 0 ? {5'h00, CS_EXT_RISE} : {5'h00, CS_EXT_FALL});
      lfsr = next_lfsr(lfsr);
      start_burst({3'h0, lfsr[4:0]} + 8'h01);
      model_count += lfsr[4:0] + 1;
      for (int n = 0; n < 400 && ext_done !== 1'b1; n++) @(posedge mclk);
      wr(REG_CONTROL_B, 8'h00);
      rd(REG_COUNTER, rd0);
      check(rd0, 8'(model_count));
    end
    // Pin edge to counter wrap: third clock edge after the pin change
    wr(REG_COUNTER, 8'hff);
    wr(REG_FLAGS, 8'h07);
    wr(REG_MASK, 8'h01);
    wr(REG_CONTROL_B, {5'h00, CS_EXT_RISE});
    start_burst(8'h01);
    @(posedge pin);
    repeat (2) @(posedge mclk);
    #1 check({7'h00, irq_ov}, 8'h00);
    @(posedge mclk);
    #1 check({7'h00, irq_ov}, 8'h01);
    repeat (20) @(posedge mclk);
    report_and_stop();
  end
endmodule
